// ### logic/tws_slave.sv
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_slave
  import tws_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [9:0] monitor_result_bits_in,
  output tws_ctrl_s       ctrl_out,
  output logic            busy_out
);
  logic       scl_q;
  logic       sda_q;
  tws_state_e state_q;
  logic [2:0] bit_q;
  logic       addr_full_q;
  logic [7:0] shift_q;
  logic       rd_q;
  logic [1:0] byte_q;
  logic [3:0] index_q;
  logic       ack_q;
  logic       drive_q;
  logic [7:0] regs_q [0:15];
  logic       reg_we;
  logic [7:0] rd_data;
  logic [7:0] wmask;
  logic [7:0] shift_in;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       addr_hit;

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;  // RULE2
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;  // RULE3
  assign shift_in   = {shift_q[6:0], sda_in};
  assign addr_hit   = shift_q[7:1] == `TWS_DEV_ADDR;     // RULE4

  // Per-register writable bits; zero masks cover unused and read-only slots
  assign wmask =
    (index_q == `TWS_REG_EMPH)     ? `TWS_MASK_EMPH     :  // RULE20
    (index_q == `TWS_REG_ARANGE)   ? `TWS_MASK_ARANGE   :
    (index_q == `TWS_REG_BACKTERM) ? `TWS_MASK_BACKTERM :
    (index_q == `TWS_REG_MONSET)   ? `TWS_MASK_MONSET   :
    (index_q <= `TWS_REG_BACKTERM) ? 8'hff : 8'h00;        // RULE26 RULE27

  assign rd_data =
    (index_q == `TWS_REG_MON_HI) ? monitor_result_bits_in[9:2] :          // RULE22
    (index_q == `TWS_REG_MON_LO) ? {6'h00, monitor_result_bits_in[1:0]} :
    regs_q[index_q];

  assign reg_we = (state_q == TWS_RX) && scl_rise && (bit_q == 3'h7) && (byte_q == 2'h1);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Register bank; masked bits never store, so they read back zero except in result slots 14 and 15, which read the monitor
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_reg
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          regs_q[gi] <= `TWS_RESET_VAL;  // RULE23
        end else if (reg_we && index_q == 4'(gi)) begin
          regs_q[gi] <= shift_in & wmask;  // RULE6 RULE26 RULE27
        end
      end

      // A slot moves only on its own write strobe
      a_reg_hold: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)  // RULE6
        !(reg_we && index_q == 4'(gi)) |=> $stable(regs_q[gi]))
        else $error("register changed without write");
    end
  endgenerate

  // Protocol engine; the bus clock is always the master's (slave only)
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin  // RULE24
    if (!reset_n_in) begin
      state_q <= TWS_IDLE;
      bit_q   <= 3'h0;
      addr_full_q <= 1'b0;
      shift_q <= 8'h00;
      rd_q    <= 1'b0;
      byte_q  <= 2'h0;
      index_q <= 4'h0;
      ack_q   <= 1'b0;
      drive_q <= 1'b0;
    end else if (start_seen) begin
      state_q <= TWS_ADDR;  // RULE2
      bit_q   <= 3'h0;
      addr_full_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= TWS_IDLE;  // RULE3
      drive_q <= 1'b0;
    end else begin
      unique case (state_q)
        TWS_IDLE: drive_q <= 1'b0;  // RULE1
        TWS_ADDR: begin
          if (scl_rise) begin
            shift_q <= shift_in;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              addr_full_q <= 1'b1;
            end
          end
          // The clock fall that closes START itself must not end the byte
          if (scl_fall && addr_full_q) begin
            addr_full_q <= 1'b0;
            state_q <= TWS_ADDR_ACK;
            rd_q    <= shift_q[0];  // RULE5
            ack_q   <= addr_hit;
            drive_q <= addr_hit;    // RULE8 RULE9
          end
        end
        TWS_ADDR_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            bit_q   <= 3'h0;
            byte_q  <= 2'h0;
            if (!ack_q) begin
              state_q <= TWS_IDLE;  // RULE9
            end else if (rd_q) begin
              state_q <= TWS_TX;  // RULE7
              shift_q <= rd_data;
              drive_q <= ~rd_data[7];
            end else begin
              state_q <= TWS_RX;
            end
          end
        end
        TWS_RX: begin
          if (scl_rise) begin
            shift_q <= shift_in;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7 && byte_q == 2'h0) begin
              index_q <= shift_in[3:0];
            end
          end
          if (scl_fall && bit_q == 3'h0 && byte_q != 2'h3) begin
            state_q <= TWS_RX_ACK;
            drive_q <= (byte_q != 2'h2);  // RULE10
          end
        end
        TWS_RX_ACK: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            state_q <= TWS_RX;
            byte_q  <= (byte_q == 2'h0) ? 2'h1 : 2'h2;
          end
        end
        TWS_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_q <= TWS_TX_ACK;
              drive_q <= 1'b0;  // RULE8
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              drive_q <= ~shift_q[6];
            end
          end
        end
        TWS_TX_ACK: begin
          // One byte per read; master's answer ends our part either way
          if (scl_fall) begin
            state_q <= TWS_IDLE;  // RULE7
          end
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out    = 1'b0;
  assign sda_oe_out = drive_q;
  assign busy_out   = state_q != TWS_IDLE;

  // Control fields straight from the bank (RULE11..RULE21)
  always_comb begin
    ctrl_out.chip_on                  = regs_q[0][`TWS_BIT_CHIP_ON];     // RULE11
    ctrl_out.weak_pullup_sel          = regs_q[0][`TWS_BIT_WEAK_PU];     // RULE12
    ctrl_out.emphasis_on              = regs_q[0][`TWS_BIT_EMPH_ON];     // RULE13
    ctrl_out.emphasis_range           = regs_q[0][`TWS_BIT_EMPH_RNG];    // RULE14
    ctrl_out.crossing_adjust_on       = regs_q[0][`TWS_BIT_CROSS_ON];    // RULE15
    ctrl_out.output_invert            = regs_q[0][`TWS_BIT_INVERT];      // RULE16
    ctrl_out.equalizer_on             = regs_q[0][`TWS_BIT_EQ_ON];       // RULE17
    ctrl_out.amplitude_source_sel     = regs_q[0][`TWS_BIT_AMP_SRC];     // RULE18
    ctrl_out.amplitude_code           = regs_q[1];                       // RULE19
    ctrl_out.emphasis_height          = regs_q[2][3:0];                  // RULE20
    ctrl_out.equalizer_code           = regs_q[3];                       // RULE21
    ctrl_out.crossing_adjust          = regs_q[4];
    ctrl_out.amplitude_range_settings = regs_q[5];
    ctrl_out.limiter_follower_current = regs_q[6];
    ctrl_out.back_termination_control = regs_q[7];
    ctrl_out.monitor_settings         = regs_q[13];
  end

  a_idle_release: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_IDLE |=> !sda_oe_out) else $error("data driven while idle");  // RULE1
  a_start_addr: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    start_seen |=> state_q == TWS_ADDR) else $error("start missed");  // RULE2
  a_stop_idle: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    stop_seen && !start_seen |=> state_q == TWS_IDLE) else $error("stop missed");  // RULE3
  a_addr_match: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_ADDR_ACK && $changed(state_q) |-> sda_oe_out == (shift_q[7:1] == 7'h08))
    else $error("address ack wrong");  // RULE4
  a_miss_release: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_ADDR_ACK && !ack_q |-> !sda_oe_out) else $error("ack on mismatch");  // RULE9
  a_tx_release: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_TX_ACK |-> !sda_oe_out) else $error("tx held ack slot");  // RULE8
  a_extra_nack: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_RX_ACK && byte_q == 2'h2 |-> !sda_oe_out) else $error("extra byte acked");  // RULE10
  a_ro_stable: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ##1 $stable(regs_q[14]) && regs_q[8] == 8'h00) else $error("ro or unused changed");  // RULE26 RULE27
  a_emph_upper: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    regs_q[2][7:4] == 4'h0) else $error("reserved emphasis bits set");  // RULE20
  c_write: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in) reg_we);
  c_read: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in) state_q == TWS_TX);
  c_miss: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_ADDR_ACK && !ack_q);
  c_extra: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state_q == TWS_RX_ACK && byte_q == 2'h2);
  c_restart: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    start_seen && busy_out);

  // Assertion helpers only; nothing here feeds the bus engine
  logic       wrote_q;
  logic       tx_first_q;
  logic [9:0] mon_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wrote_q <= 1'b0;
    end else if (start_seen || stop_seen) begin
      wrote_q <= 1'b0;
    end else if (reg_we) begin
      wrote_q <= 1'b1;
    end
  end

  // Snapshot of the live result at the edge that loads the read byte
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_first_q <= 1'b0;
      mon_q      <= 10'h000;
    end else begin
      tx_first_q <= (state_q == TWS_ADDR_ACK) && scl_fall && ack_q && rd_q
                    && !start_seen && !stop_seen;
      mon_q      <= monitor_result_bits_in;
    end
  end

  // Ack must stand through the whole high phase of the ninth pulse
  property p_ack_holds;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state_q == TWS_RX_ACK || state_q == TWS_ADDR_ACK) && sda_oe_out && scl_in && scl_q
      |=> sda_oe_out;
  endproperty
  a_ack_holds: assert property (p_ack_holds)  // RULE8
    else $error("ack dropped in high phase");

  // Read data may only move after a clock fall
  property p_tx_steady;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == TWS_TX && !scl_fall && !start_seen && !stop_seen |=> $stable(sda_oe_out);
  endproperty
  a_tx_steady: assert property (p_tx_steady)  // RULE8
    else $error("read bit moved in clock high");

  // Address byte needs all eight rises before its ack slot
  property p_addr_eight;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == TWS_ADDR && scl_fall && !addr_full_q |=> state_q != TWS_ADDR_ACK;
  endproperty
  a_addr_eight: assert property (p_addr_eight)  // RULE4
    else $error("address byte cut short");

  property p_start_release;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      start_seen |=> !sda_oe_out && bit_q == 3'h0;
  endproperty
  a_start_release: assert property (p_start_release)  // RULE2
    else $error("start did not restart");

  property p_stop_release;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      stop_seen |=> !sda_oe_out;
  endproperty
  a_stop_release: assert property (p_stop_release)  // RULE3
    else $error("data held after stop");

  property p_idle_quiet;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      !busy_out |-> !sda_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)  // RULE1
    else $error("idle bus pulled low");

  // Only one data byte lands per transfer
  property p_one_write;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      wrote_q |-> !reg_we;
  endproperty
  a_one_write: assert property (p_one_write)  // RULE10
    else $error("second write in one transfer");

  property p_no_stray;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      !reg_we |=> $stable(ctrl_out);
  endproperty
  a_no_stray: assert property (p_no_stray)  // RULE6
    else $error("control moved without write");

  // Turning the chip off must not disturb other settings
  property p_off_keeps;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      $fell(ctrl_out.chip_on) |-> $stable(ctrl_out.amplitude_code)
      && $stable(ctrl_out.equalizer_code);
  endproperty
  a_off_keeps: assert property (p_off_keeps)  // RULE11
    else $error("disable cleared settings");

  property p_one_read;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == TWS_TX_ACK |=> state_q != TWS_TX;
  endproperty
  a_one_read: assert property (p_one_read)  // RULE7
    else $error("second read byte sent");

  property p_rx_aligned;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == TWS_RX_ACK |-> bit_q == 3'h0;
  endproperty
  a_rx_aligned: assert property (p_rx_aligned)  // RULE6
    else $error("ack slot off byte boundary");

  property p_unused_zero;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      regs_q[9] == 8'h00 && regs_q[12] == 8'h00 && regs_q[15] == 8'h00
      && (regs_q[5] & ~`TWS_MASK_ARANGE) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)  // RULE26
    else $error("unused bits stored");

  // Result registers read the converter, never the bank
  property p_mon_high;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      tx_first_q && index_q == `TWS_REG_MON_HI |-> shift_q == mon_q[9:2];
  endproperty
  a_mon_high: assert property (p_mon_high)  // RULE22
    else $error("result high byte wrong");

  property p_mon_low;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      tx_first_q && index_q == `TWS_REG_MON_LO |-> shift_q == {6'h00, mon_q[1:0]};
  endproperty
  a_mon_low: assert property (p_mon_low)  // RULE22
    else $error("result low bits wrong");
endmodule  // tws_slave

// ### logic/tws_regs.svh
// What this block does
// RULE1: Idle means both lines high; device never pulls data low while idle.
// RULE2: START is data falling while clock high; detected at any time.
// RULE3: STOP is data rising while clock high; device returns to idle.
// RULE4: First seven bits after START, MSB first, must match fixed address.
// RULE5: Eighth bit is direction: 0 write, 1 read.
// RULE6: Write is address, register index, one data byte, STOP; each acknowledged.
// RULE7: Read sets index by write, repeated START, address with read, one byte.
// RULE8: Receiver holds data low through ninth clock high; transmitter releases.
// RULE9: On address mismatch the device leaves data high at acknowledge.
// RULE10: Extra bytes after the one data byte get not-acknowledge.
// RULE11: Main control bit 7 enables output; clearing it keeps registers.
// RULE12: Main control bit 6 selects weak pull-up; exported as output.
// RULE13: Bit 5 enables pre-emphasis with height from register 2.
// RULE14: Bit 4 selects high pre-emphasis range; exported as output.
// RULE15: Bit 3 picks crossing adjust (1) or offset cancellation (0).
// RULE16: Bit 2 swaps output polarity.
// RULE17: Bit 1 enables input equalizer with boost from register 3.
// RULE18: Bit 0 picks digital amplitude register (1) or analog pin (0).
// RULE19: Register 1 holds the 8-bit amplitude code, 256 steps.
// RULE20: Register 2 low four bits set emphasis height; upper bits unused.
// RULE21: Register 3 holds inverse-sense equalizer code.
// RULE22: Registers 14 and 15 return monitor result high eight and low two bits.
// RULE23: Reset clears every register to zero.
// RULE24: Device is slave only; master supplies clock and START.
// RULE25: Software reads the two monitor halves with two transfers.
// RULE26: Unused registers and reserved bits ignore writes and read zero.
// RULE27: Writes to read-only result registers are acknowledged, no effect.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_DEV_ADDR      7'h08
`define TWS_REG_MAIN      4'h0
`define TWS_REG_AMP       4'h1
`define TWS_REG_EMPH      4'h2
`define TWS_REG_EQ        4'h3
`define TWS_REG_CROSS     4'h4
`define TWS_REG_ARANGE    4'h5
`define TWS_REG_LIMFOL    4'h6
`define TWS_REG_BACKTERM  4'h7
`define TWS_REG_MONSET    4'hd
`define TWS_REG_MON_HI    4'he
`define TWS_REG_MON_LO    4'hf
`define TWS_MASK_EMPH     8'h0f
`define TWS_MASK_ARANGE   8'heb
`define TWS_MASK_BACKTERM 8'hcf
`define TWS_MASK_MONSET   8'hc1
`define TWS_RESET_VAL     8'h00
`define TWS_BIT_CHIP_ON   7
`define TWS_BIT_WEAK_PU   6
`define TWS_BIT_EMPH_ON   5
`define TWS_BIT_EMPH_RNG  4
`define TWS_BIT_CROSS_ON  3
`define TWS_BIT_INVERT    2
`define TWS_BIT_EQ_ON     1
`define TWS_BIT_AMP_SRC   0
`endif

// ### logic/tws_pkg.sv
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_RX, TWS_RX_ACK, TWS_TX, TWS_TX_ACK
  } tws_state_e;
  typedef struct packed {
    logic       chip_on;
    logic       weak_pullup_sel;
    logic       emphasis_on;
    logic       emphasis_range;
    logic       crossing_adjust_on;
    logic       output_invert;
    logic       equalizer_on;
    logic       amplitude_source_sel;
    logic [7:0] amplitude_code;
    logic [3:0] emphasis_height;
    logic [7:0] equalizer_code;
    logic [7:0] crossing_adjust;
    logic [7:0] amplitude_range_settings;
    logic [7:0] limiter_follower_current;
    logic [7:0] back_termination_control;
    logic [7:0] monitor_settings;
  } tws_ctrl_s;
endpackage

// ### tb/tws_master.sv
`timescale 1ns/1ps
module tws_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // Half bit time in system clocks; raised by the bench for a slow master
  int hp = 4;
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // Also serves as repeated start, from clock low
  task automatic start();
    sda_oe_out = 1'b0;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    sda_oe_out = 1'b1;
    tick(hp);
    scl_out = 1'b0;
    tick(hp);
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    sda_oe_out = 1'b0;
    tick(hp);
  endtask
  task automatic put_bit(input logic b, output logic got);
    sda_oe_out = ~b;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    got = sda_in;
    scl_out = 1'b0;
    tick(1);
  endtask
  // Ninth bit always released: write ack seen, read data gets not-ack
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(1'b1, g);
    ack = ~g;
  endtask
endmodule // tws_master

// ### tb/tb_two_wire_slave_control_regs.sv
`timescale 1ns/1ps
`include "tws_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module tb_two_wire_slave_control_regs
  import tws_pkg::*;
;
  logic       clk_sys, reset_n, scl, m_oe, s_out, s_oe, busy;
  logic [9:0] mon;
  tws_ctrl_s  ctrl;
  wire        sda = ~m_oe & (~s_oe | s_out);
  int         err_total, cmp_count, mdl[16];
  logic [15:0] lfsr = 16'h0039;
  tws_slave i_tws_slave (.clk_sys_in(clk_sys), .reset_n_in(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(s_out), .sda_oe_out(s_oe), .monitor_result_bits_in(mon),
    .ctrl_out(ctrl), .busy_out(busy));
  tws_master i_tws_master (.clk_in(clk_sys), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic int msk(input int r);
    case (r)
      0, 1, 3, 4, 6: return 8'hff;
      2:             return `TWS_MASK_EMPH;
      5:             return `TWS_MASK_ARANGE;
      7:             return `TWS_MASK_BACKTERM;
      13:            return `TWS_MASK_MONSET;
      default:       return 0; // Unused and read-only places keep nothing
    endcase
  endfunction
  function automatic logic [67:0] exp_ctrl();
    return {8'(mdl[0]), 8'(mdl[1]), 4'(mdl[2]), 8'(mdl[3]), 8'(mdl[4]), 8'(mdl[5]),
            8'(mdl[6]), 8'(mdl[7]), 8'(mdl[13])};
  endfunction
  task automatic wr(input logic [6:0] a, input int r, input logic [7:0] d, input bit extra);
    logic [7:0] rx;
    logic k;
    i_tws_master.start();
    i_tws_master.xfer({a, 1'b0}, rx, k);
    `CHK(k, a == `TWS_DEV_ADDR)
    if (k === 1'b1) begin
      i_tws_master.xfer(8'(r), rx, k);
      `CHK(k, 1'b1)
      i_tws_master.xfer(d, rx, k);
      `CHK(k, 1'b1)
      mdl[r] = d & msk(r);
      if (extra) begin
        i_tws_master.xfer(~d, rx, k);
        `CHK(k, 1'b0)
      end
    end
    i_tws_master.stop();
    `CHK(busy, 1'b0)
    `CHK(s_oe, 1'b0)
    `CHK(ctrl, exp_ctrl())
  endtask
  task automatic rd(input int r);
    logic [7:0] rx, want;
    logic k;
    mon = 10'(rnd());
    i_tws_master.start();
    i_tws_master.xfer(8'h10, rx, k);
    i_tws_master.xfer(8'(r), rx, k);
    `CHK(k, 1'b1)
    i_tws_master.start();
    i_tws_master.xfer(8'h11, rx, k);
    `CHK(k, 1'b1)
    i_tws_master.xfer(8'hff, rx, k);
    i_tws_master.stop();
    want = (r == 14) ? mon[9:2] : (r == 15) ? {6'h00, mon[1:0]} : 8'(mdl[r]);
    `CHK(rx, want)
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial begin
    logic b;
    reset_n = 1'b0;
    mon = 10'h000;
    repeat (8) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    `CHK(ctrl, 68'h0)
    for (int r = 0; r < 16; r++) rd(r);
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      i_tws_master.hp = 4 + 3 * p;
      for (int r = 0; r < 16; r++) wr(7'h08, r, 8'(rnd()), 1'b0);
      for (int r = 0; r < 16; r++) rd(r);
    end
    $display("test register map done");
    wr(7'h09, 0, 8'h5a, 1'b0);
    wr(7'h48, 1, 8'ha5, 1'b0);
    rd(0);
    rd(1);
    $display("test foreign address done");
    wr(7'h08, 1, 8'h3c, 1'b1);
    rd(1);
    $display("test extra byte done");
    // Start cut into a byte must resynchronise
    i_tws_master.start();
    for (int i = 0; i < 4; i++) i_tws_master.put_bit(1'b1, b);
    wr(7'h08, 3, 8'hc3, 1'b0);
    rd(3);
    $display("test start in byte done");
    #2 reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    `CHK(ctrl, 68'h0)
    rd(0);
    $display("test second reset done");
    summarize();
  end
endmodule // tb_two_wire_slave_control_regs
